// [inc/pulser_defines.vh]
/*
  Constants for the one-speed positioning pulser: APB register offsets,
  field positions, reset values, clock rate and operand limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PULSER_DEFINES_VH
`define PULSER_DEFINES_VH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CLK_HZ            32'd10_000_000
`define FREQ_MIN_HZ       32'h0000_000A
`define FREQ_MAX_HW_HZ    32'h0003_0D40
`define FREQ_MAX_TR_HZ    32'h0001_86A0
`define FREQ_MAX_16_HZ    32'h0000_7FFF

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL          12'h000
`define OFS_COUNT         12'h004
`define OFS_FREQ          12'h008
`define OFS_STATUS        12'h00C
`define OFS_CONFIG        12'h010
`define OFS_POS_BASE      12'h020
`define OFS_POS_MASK      12'hFE0
`define POS_IDX_LO        2
`define POS_IDX_HI        4

// ----------------------------------------------------------------------
// Control register fields (write one to start)
// ----------------------------------------------------------------------
`define CTRL_START        0
`define CTRL_ABS          1
`define CTRL_WIDE         2
`define CTRL_CH_LO        4
`define CTRL_CH_HI        5
`define CTRL_DIR_LO       8
`define CTRL_DIR_HI       10

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_DONE         0
`define STAT_ERR          1
`define STAT_BUSY_LO      4

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define CFG_EXPANSION     0
`define CFG_SECOND_ADP    1

// ----------------------------------------------------------------------
// Operand limits
// ----------------------------------------------------------------------
`define CNT16_MIN         32'hFFFF_8000
`define CNT16_MAX         32'h0000_7FFF
`define CNT32_MIN         32'hFFF0_BDC1
`define CNT32_MAX         32'h000F_423F
`define POS_RESET         32'h0000_0000
`define ZERO32            32'h0000_0000
`define ONE32             32'h0000_0001

`endif

// [hdl/rate_divider.v]
/*
  Phase accumulator that emits a one-cycle enable at the requested rate.
  Assumes rate in Hz below half the clock rate; restarts on clear.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pulser_defines.vh"

module rate_divider #(
  parameter integer CLK_RATE = 10_000_000
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_clear,
  input  wire [31:0] i_rate_hz,
  output reg         o_tick
);

  reg  [31:0] acc;
  wire [32:0] sum;
  localparam [32:0] LIMIT = CLK_RATE;

  assign sum = {1'b0, acc} + {1'b0, i_rate_hz};

  // ----------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc    <= `ZERO32;
      o_tick <= 1'b0;
    end else if (i_clear) begin
      acc    <= `ZERO32;
      o_tick <= 1'b0;
    end else if (sum >= LIMIT) begin
      acc    <= sum[31:0] - LIMIT[31:0];
      o_tick <= 1'b1;
    end else begin
      acc    <= sum[31:0];
      o_tick <= 1'b0;
    end
  end

endmodule // rate_divider

`default_nettype wire

// [hdl/pos_counter.v]
/*
  One 32-bit current position register with per-pulse step and load.
  Assumes step and load are single-cycle pulses on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pulser_defines.vh"

module pos_counter (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_load,
  input  wire [31:0] i_load_val,
  input  wire        i_step,
  input  wire        i_down,
  output reg  [31:0] o_pos
);

  // ----------------------------------------------------------------------
  // Position register
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // RULE9 resets to zero
      o_pos <= `POS_RESET;
    end else if (i_load) begin
      o_pos <= i_load_val;
    end else if (i_step) begin
      // RULE12 one per pulse
      o_pos <= i_down ? o_pos - `ONE32 : o_pos + `ONE32;
    end
  end

endmodule // pos_counter

`default_nettype wire

// [hdl/one_speed_positioning_pulser.v]
/*
  One-speed positioning pulse generator with an APB register slave.
  Software writes count, frequency, then control to start a relative or
  absolute move; the block drives pulses on the chosen channel and
  direction on the chosen direction output, and tracks position per channel.
  Assumes a single 10 MHz clock and an APB master on the same clock.
*/
// Notes on behaviour
// RULE1: Relative move adds signed count to current position; sign sets direction.
// RULE2: Absolute move travels from current position to target measured from origin.
// RULE3: Requester gives 16-bit count in -32768..+32767, never zero.
// RULE4: Requester gives 32-bit count in -999999..+999999, never zero.
// RULE5: Requester gives 16-bit frequency between 10 and 32767 Hz.
// RULE6: 32-bit frequency up to 200000 Hz expansion, 100000 Hz transistor.
// RULE7: Channel 0..2 on transistor outputs, 0..3 expansion; 2,3 need second adapter.
// RULE8: Selected direction output shows rotation direction of current move.
// RULE9: Each channel owns a 32-bit current position register resetting to zero.
// RULE10: Each channel has read-only busy flag for pulse output.
// RULE11: Shared read-only complete flag sets when a positioning command ends.
// RULE12: Emit |travel| pulses at commanded rate, step position each pulse, stop.
`timescale 1ns/100ps
`default_nettype none
`include "pulser_defines.vh"

module one_speed_positioning_pulser #(
  parameter integer CLK_RATE = 10_000_000,
  parameter integer CHANNELS = 4,
  parameter integer DIR_OUTS = 8
) (
  input  wire                i_clk,
  input  wire                i_rst_n,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  output reg  [CHANNELS-1:0] o_pulse_channel,
  output reg  [DIR_OUTS-1:0] o_direction,
  output reg                 o_exec_complete_flag,
  output reg  [CHANNELS-1:0] o_pulse_monitor_flag
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_HIGH  = 2'd1;
  localparam [1:0] ST_LOW   = 2'd2;

  reg  [1:0]          state;
  reg  [31:0]         count_operand;
  reg  [31:0]         freq_operand;
  reg  [1:0]          cfg;
  reg                 cmd_error;
  reg  [1:0]          chan;
  reg  [2:0]          dir_sel;
  reg                 dir_down;
  reg  [31:0]         remaining;
  reg  [31:0]         rate_x2;
  wire                tick;
  wire [CHANNELS-1:0] step;
  wire [31:0]         pos [0:CHANNELS-1];

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function slt;
    input [31:0] a;
    input [31:0] b;
    begin
      slt = (a[31] != b[31]) ? a[31] : (a < b);
    end
  endfunction

  function [31:0] magnitude;
    input [31:0] v;
    begin
      magnitude = v[31] ? (`ZERO32 - v) : v;
    end
  endfunction

  function pos_slot;
    input [11:0] addr;
    begin
      pos_slot = ((addr & `OFS_POS_MASK) == `OFS_POS_BASE) && (addr[1:0] == 2'b00)
                 && (addr[`POS_IDX_HI:`POS_IDX_LO] < CHANNELS);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire        apb_wr    = psel && penable && pwrite && pready;
  wire        start_req = apb_wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_START];
  wire        is_abs    = pwdata[`CTRL_ABS];
  wire        is_wide   = pwdata[`CTRL_WIDE];
  wire [1:0]  req_ch    = pwdata[`CTRL_CH_HI:`CTRL_CH_LO];
  wire [2:0]  req_dir   = pwdata[`CTRL_DIR_HI:`CTRL_DIR_LO];
  wire [31:0] cur_pos   = pos[req_ch];

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire        setup     = psel && !penable;
  wire        rd_req    = setup && !pwrite;
  wire        pos_ok    = pos_slot(paddr);
  wire [2:0]  pos_idx   = paddr[`POS_IDX_HI:`POS_IDX_LO];
  wire        wr_count  = apb_wr && (paddr == `OFS_COUNT);
  wire        wr_freq   = apb_wr && (paddr == `OFS_FREQ);
  wire        wr_config = apb_wr && (paddr == `OFS_CONFIG);
  wire        known     = pos_ok || (paddr == `OFS_CTRL) || (paddr == `OFS_COUNT)
                          || (paddr == `OFS_FREQ) || (paddr == `OFS_STATUS)
                          || (paddr == `OFS_CONFIG);
  wire [31:0] status    = {{(32 - `STAT_BUSY_LO - CHANNELS){1'b0}}, o_pulse_monitor_flag,
                           2'b00, cmd_error, o_exec_complete_flag};
  // RULE1 relative travel
  // RULE2 absolute travel
  wire [31:0] travel    = is_abs ? (count_operand - cur_pos) : count_operand;
  wire [31:0] fmax      = !is_wide ? `FREQ_MAX_16_HZ :
                          cfg[`CFG_EXPANSION] ? `FREQ_MAX_HW_HZ : `FREQ_MAX_TR_HZ;
  // RULE7 channel legality
  wire        ch_ok     = cfg[`CFG_EXPANSION] ?
                          (req_ch < 2'd2 || cfg[`CFG_SECOND_ADP]) : (req_ch != 2'd3);
  // RULE3 16-bit count range
  // RULE4 32-bit count range
  wire        cnt_ok    = is_wide ?
                          !slt(count_operand, `CNT32_MIN) && !slt(`CNT32_MAX, count_operand) :
                          !slt(count_operand, `CNT16_MIN) && !slt(`CNT16_MAX, count_operand);
  // RULE5 16-bit frequency
  // RULE6 32-bit frequency
  wire        frq_ok    = (freq_operand >= `FREQ_MIN_HZ) && (freq_operand <= fmax);
  wire        cmd_ok    = ch_ok && cnt_ok && frq_ok && (count_operand != `ZERO32)
                          && (travel != `ZERO32);

  // ----------------------------------------------------------------------
  // Half-period enable
  // ----------------------------------------------------------------------
  rate_divider #(
    .CLK_RATE  (CLK_RATE)
  ) u_rate (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (state == ST_IDLE),
    .i_rate_hz (rate_x2),
    .o_tick    (tick)
  );

  // ----------------------------------------------------------------------
  // Pulse sequencer
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state                <= ST_IDLE;
      chan                 <= 2'd0;
      dir_sel              <= 3'd0;
      dir_down             <= 1'b0;
      remaining            <= `ZERO32;
      rate_x2              <= `ZERO32;
      cmd_error            <= 1'b0;
      o_exec_complete_flag <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            o_exec_complete_flag <= 1'b0;
            if (cmd_ok) begin
              cmd_error <= 1'b0;
              chan      <= req_ch;
              dir_sel   <= req_dir;
              dir_down  <= travel[31];
              // RULE12 pulse count
              remaining <= magnitude(travel);
              rate_x2   <= {freq_operand[30:0], 1'b0};
              state     <= ST_HIGH;
            end else begin
              cmd_error            <= 1'b1;
              o_exec_complete_flag <= 1'b1;
            end
          end
        end
        ST_HIGH: begin
          if (tick) begin
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            remaining <= remaining - `ONE32;
            if (remaining == `ONE32) begin
              // RULE11 completion flag
              o_exec_complete_flag <= 1'b1;
              state                <= ST_IDLE;
            end else begin
              state <= ST_HIGH;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel position, pulse and busy outputs
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      // RULE9 load while idle
      wire load_hit;
      assign load_hit = apb_wr && pos_ok && (pos_idx == g) && !o_pulse_monitor_flag[g];
      assign step[g] = (state == ST_HIGH) && tick && (chan == g);
      pos_counter u_pos (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_load     (load_hit),
        .i_load_val (pwdata),
        .i_step     (step[g]),
        .i_down     (dir_down),
        .o_pos      (pos[g])
      );
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_pulse_channel[g]      <= 1'b0;
          o_pulse_monitor_flag[g] <= 1'b0;
        end else begin
          // RULE12 pulse output
          o_pulse_channel[g]      <= (state == ST_HIGH) && (chan == g);
          // RULE10 busy flag
          o_pulse_monitor_flag[g] <= (state != ST_IDLE) && (chan == g);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Direction outputs
  // ----------------------------------------------------------------------
  integer d;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_direction <= {DIR_OUTS{1'b0}};
    end else begin
      for (d = 0; d < DIR_OUTS; d = d + 1) begin
        // RULE8 direction level
        if (state != ST_IDLE && dir_sel == d) begin
          o_direction[d] <= !dir_down;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ZERO32;
    end else begin
      pready  <= setup;
      pslverr <= setup && !known;
      prdata  <= `ZERO32;
      if (rd_req) begin
        if (paddr == `OFS_COUNT) begin
          prdata <= count_operand;
        end else if (paddr == `OFS_FREQ) begin
          prdata <= freq_operand;
        end else if (paddr == `OFS_CONFIG) begin
          prdata <= {30'h0000_0000, cfg};
        end else if (paddr == `OFS_STATUS) begin
          prdata <= status;
        end else if (pos_ok) begin
          prdata <= pos[pos_idx[1:0]];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operand and configuration registers
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_operand <= `ZERO32;
      freq_operand  <= `ZERO32;
      cfg           <= 2'b00;
    end else begin
      if (wr_count) begin
        count_operand <= pwdata;
      end
      if (wr_freq) begin
        freq_operand <= pwdata;
      end
      if (wr_config) begin
        cfg <= pwdata[1:0];
      end
    end
  end

endmodule // one_speed_positioning_pulser

`default_nettype wire

// [dv/drive_model.sv]
/*
  Step counting drive on the pulse and direction lines.
  Assumes direction line of channel n is line n+4.
*/
`timescale 1ns/100ps
`default_nettype none

module drive_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_pulse,
  input  wire logic [7:0] i_dir,
  output var  int         o_steps [4]
);
  logic [3:0] last;

  initial begin
    last = 4'h0;
    foreach (o_steps[k]) o_steps[k] = 0;
  end

  always @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_pulse[k] && !last[k]) o_steps[k] <= o_steps[k] + (i_dir[k + 4] ? 1 : -1);
    end
    last <= i_pulse;
  end
endmodule // drive_model

`default_nettype wire

// [dv/pulser_assertions.sv]
/*
  Port checker for the positioning pulser.
  Assumes the top module ports and an APB master on i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pulser_defines.vh"

module pulser_assertions #(
  parameter integer CHANNELS = 4,
  parameter integer DIR_OUTS = 8
) (
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [CHANNELS-1:0] o_pulse_channel,
  input wire logic [DIR_OUTS-1:0] o_direction,
  input wire logic                o_exec_complete_flag,
  input wire logic [CHANNELS-1:0] o_pulse_monitor_flag
);
  wire logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == `OFS_CTRL);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  a_error_unmapped: assert property (s_setup and paddr >= 12'h030 |=> pslverr)
    else $error("no pslverr on unmapped address");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_busy_from_start: assert property (
    (o_pulse_monitor_flag & ~$past(o_pulse_monitor_flag)) != 0 |-> $past(ctrl_wr, 2))
    else $error("busy rose without a start");
  a_pulse_while_busy: assert property ((o_pulse_channel & ~o_pulse_monitor_flag) == 0)
    else $error("pulse on an idle channel");
  a_direction_at_start: assert property (
    $changed(o_direction) |-> $past(ctrl_wr, 1) || $past(ctrl_wr, 2))
    else $error("direction moved without a start");
  a_done_before_idle: assert property (
    (~o_pulse_monitor_flag & $past(o_pulse_monitor_flag)) != 0
      |-> o_exec_complete_flag && $past(o_exec_complete_flag))
    else $error("busy fell before complete");
  a_done_clear_start: assert property (
    $fell(o_exec_complete_flag) |-> $past(ctrl_wr, 1) || $past(ctrl_wr, 2))
    else $error("complete cleared without a start");
  a_pulse_high_hold: assert property ($rose(|o_pulse_channel) |=> (|o_pulse_channel)[*8])
    else $error("pulse high phase too short");
endmodule // pulser_assertions

bind one_speed_positioning_pulser pulser_assertions #(.CHANNELS(CHANNELS),
  .DIR_OUTS(DIR_OUTS)) i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .o_pulse_channel(o_pulse_channel),
  .o_direction(o_direction), .o_exec_complete_flag(o_exec_complete_flag),
  .o_pulse_monitor_flag(o_pulse_monitor_flag));

`default_nettype wire

// [dv/one_speed_positioning_pulser_test.sv]
/*
  Self-checking bench: APB master, position model, drive model.
  Assumes the design answers APB and drives channels as handed over.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pulser_defines.vh"

module one_speed_positioning_pulser_test;
  logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pulse, busy;
  logic [7:0]  dir;
  int          steps [4];
  int          pos [4];
  int          fails, samples_checked, cnt;
  int          bad [9][6] = '{'{1, 0, 0, 1, 0, 200000}, '{1, 0, 0, 0, 32768, 1000},
    '{1, 0, 0, 1, 1000000, 1000}, '{1, 0, 0, 0, 5, 9}, '{1, 0, 0, 0, 5, 32768},
    '{1, 0, 0, 1, 5, 200001}, '{0, 0, 0, 1, 5, 100001}, '{1, 2, 0, 1, 5, 1000},
    '{0, 3, 0, 1, 5, 1000}};

  one_speed_positioning_pulser i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_pulse_channel(pulse), .o_direction(dir),
    .o_exec_complete_flag(done), .o_pulse_monitor_flag(busy));
  drive_model i_drive (.i_clk(i_clk), .i_pulse(pulse), .i_dir(dir), .o_steps(steps));

  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic xerr = 1'b0);
    int n;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 20) begin
        check("pready wait", 32'h0000_0000, 32'h0000_0001);
        close_out();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    check("pslverr", 32'(pslverr), 32'(xerr));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_busy(input int ch, input logic lvl);
    int n;
    n = 0;
    while (busy[ch] !== lvl) begin
      @(posedge i_clk);
      n++;
      if (n > 30000) begin
        check("wait", 32'h0000_0000, 32'h0000_0001);
        close_out();
      end
    end
  endtask

  function automatic bit legal(int cfg, int ch, int wide, int c, int frq, int trv);
    int fmax;
    fmax = !wide ? 32767 : (cfg[0] ? 200000 : 100000);
    return trv != 0 && frq >= 10 && frq <= fmax && (cfg[0] ? (ch < 2 || cfg[1]) : ch < 3)
      && c != 0 && (wide ? (c >= -999999 && c <= 999999) : (c >= -32768 && c <= 32767));
  endfunction

  task automatic move(input int cfg, ch, ab, wide, c, frq, input int hold = 0);
    int s0, trv, n;
    bit ok;
    logic [31:0] ctl;
    trv = ab ? c - pos[ch] : c;
    ok = legal(cfg, ch, wide, c, frq, trv);
    s0 = steps[ch];
    ctl = 32'(1 + 2 * ab + 4 * wide + 16 * ch + 256 * (ch + 4));
    apb(1'b1, `OFS_CONFIG, 32'(cfg));
    apb(1'b1, `OFS_COUNT, 32'(c));
    apb(1'b1, `OFS_FREQ, 32'(frq));
    apb(1'b1, `OFS_CTRL, ctl);
    if (hold) begin
      apb(1'b1, 12'(`OFS_POS_BASE + 4 * ch), 32'h0000_004D);
      apb(1'b1, `OFS_CTRL, ctl);
    end
    if (ok) begin
      wait_busy(ch, 1'b1);
      check("direction", 32'(dir[ch + 4]), 32'(trv > 0));
      wait_busy(ch, 1'b0);
      pos[ch] += trv;
    end else begin
      n = 0;
      do begin
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        n++;
      end while (rd[1] !== 1'b1 && n < 10);
    end
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    check("status", rd, 32'(ok ? 1 : 3));
    check("complete", 32'(done), 32'h0000_0001);
    apb(1'b0, 12'(`OFS_POS_BASE + 4 * ch), 32'h0000_0000);
    check("position", rd, 32'(pos[ch]));
    check("steps", 32'(steps[ch] - s0), 32'(ok ? trv : 0));
  endtask

  // ----------------------------
  // Sequence
  // ----------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fails = 0;
    samples_checked = 0;
    foreach (pos[i]) pos[i] = 0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    void'($urandom(32'h8dd3));
    for (int ch = 0; ch < 4; ch++) begin
      apb(1'b0, 12'(`OFS_POS_BASE + 4 * ch), 32'h0000_0000);
      check("position reset", rd, `POS_RESET);
    end
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    check("status reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h030, 32'h0000_0000, 1'b1);
    move(1, 0, 0, 1, 3, 200000);
    move(1, 0, 1, 1, 1, 200000);
    move(0, 1, 0, 0, -2, 32767);
    apb(1'b1, 12'(`OFS_POS_BASE + 8), 32'h0000_0064);
    pos[2] = 100;
    move(0, 2, 0, 1, 2, 100000);
    move(3, 3, 0, 1, -1, 200000);
    cnt = int'($urandom_range(4, 1));
    if ($urandom_range(1, 0) == 1) cnt = -cnt;
    move(1, 1, 0, 1, cnt, 200000);
    move(1, 0, 0, 1, 2, 200000, 1);
    move(1, 0, 1, 1, pos[0], 1000);
    foreach (bad[i]) move(bad[i][0], bad[i][1], bad[i][2], bad[i][3], bad[i][4], bad[i][5]);
    close_out();
  end
endmodule // one_speed_positioning_pulser_test

`default_nettype wire
